//--- include/exec_unit_pkg.sv
// package: opcodes, register map, field layout and reset values for exec_unit
package exec_unit_pkg;

    // register map, byte addresses on the bus
    localparam logic [11:0] ADDR_INSTR = 12'h000;
    localparam logic [11:0] ADDR_ACC = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_PC = 12'h00c;
    localparam logic [11:0] ADDR_LATCH = 12'h010;
    localparam logic [11:0] ADDR_CYCLES = 12'h014;
    localparam logic [11:0] ADDR_FILE_BASE = 12'h400;
    localparam int ADDR_DEC_MSB = 11;
    localparam int FILE_WIN_MSB = 10;

    // instruction word layout
    localparam int OP_MSB = 15;
    localparam int OP_LSB = 12;
    localparam int TARGET_BIT = 7;
    localparam int SLOT_MSB = 6;
    localparam int LIT_MSB = 7;
    localparam int JUMP_MSB = 10;

    // operation codes
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_DECR = 4'h1;
    localparam logic [3:0] OP_INCR = 4'h2;
    localparam logic [3:0] OP_DECR_SKIP = 4'h3;
    localparam logic [3:0] OP_INCR_SKIP = 4'h4;
    localparam logic [3:0] OP_CLEAR_ACC = 4'h5;
    localparam logic [3:0] OP_OR_LIT = 4'h6;
    localparam logic [3:0] OP_JUMP = 4'h7;

    // status register fields
    localparam int ST_NULL_BIT = 0;
    localparam int ST_SKIP_BIT = 1;
    localparam int ST_BUSY_BIT = 2;

    // program counter and latch geometry
    localparam int PC_W = 15;
    localparam int LATCH_W = 7;
    localparam int SLOTS = 128;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 15'h0000;
    localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
    localparam logic [7:0] SLOT_RST = 8'h00;
    localparam logic [31:0] CYCLES_RST = 32'h0000_0000;

    // bus encodings
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [2:0] {
        st_run = 3'b001,
        st_jump = 3'b010,
        st_skip = 3'b100
    } exec_state_t;

endpackage : exec_unit_pkg

//--- hw/exec_unit.sv
// execution unit for the counter, accumulator and jump instruction group

// Function
// (RULE1) operands take slot 0 to 127; target bit picks accumulator or slot
// (RULE2) decrement_register subtracts one, writes target, updates null flag
// (RULE3) clear_accumulator loads zero into accumulator and sets null flag
// (RULE4) decrement_skip_on_null decrements into target, status unchanged
// (RULE5) zero skip result turns the next instruction into a no-operation
// (RULE6) increment_skip_on_null increments, keeps status, skips on zero
// (RULE7) absolute_jump loads its 11-bit target into program counter bits 10 to 0
// (RULE8) absolute_jump fills counter bits 14 to 11 from latch bits 6 to 3
// (RULE9) absolute_jump always takes two instruction cycles
// (RULE10) or_literal_into_accumulator ORs a literal in, updates null flag
// (RULE11) increment_register adds one, writes target, updates null flag
// (RULE12) counting wraps modulo 256; null flag follows zero 8-bit result
// (RULE13) non-skipping, non-jumping instructions take one instruction cycle
module exec_unit (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic o_null_flag,
    output logic o_busy,
    output logic [14:0] o_program_counter
);

    logic dph_valid_q;
    logic dph_write_q;
    logic [11:0] dph_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic [31:0] instr_q;
    logic [7:0] acc_q;
    logic null_q;
    logic [exec_unit_pkg::PC_W-1:0] pc_q;
    logic [exec_unit_pkg::LATCH_W-1:0] latch_q;
    logic [31:0] cycles_q;
    logic [31:0] cycles_d;
    exec_unit_pkg::exec_state_t state_q;
    logic [7:0] slot_q [exec_unit_pkg::SLOTS];

    logic addr_phase;
    logic bus_wr;
    logic wr_instr;
    logic killed;
    logic exec;
    logic [3:0] op;
    logic target;
    logic [6:0] slot;
    logic [7:0] literal;
    logic [10:0] jump_k;
    logic [7:0] operand;
    logic [7:0] dec_res;
    logic [7:0] inc_res;
    logic [7:0] or_res;
    logic file_op;
    logic skip_op;
    logic [7:0] file_res;
    logic wr_file_win;
    logic [6:0] win_slot;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic [11:0] rd_addr;

    // bus side decode; only whole-word single transfers are expected
    assign addr_phase = i_hsel && i_hready && i_htrans[1];
    assign bus_wr = dph_valid_q && dph_write_q;
    assign wr_instr = bus_wr && (dph_addr_q == exec_unit_pkg::ADDR_INSTR);
    assign wr_file_win = bus_wr && dph_addr_q[exec_unit_pkg::FILE_WIN_MSB];
    assign win_slot = dph_addr_q[8:2];

    // a pending skip swallows the next issued word as a no-operation
    assign killed = wr_instr && (state_q == exec_unit_pkg::st_skip); // RULE5
    assign exec = wr_instr && !killed;

    // instruction fields
    assign op = i_hwdata[exec_unit_pkg::OP_MSB:exec_unit_pkg::OP_LSB];
    assign target = i_hwdata[exec_unit_pkg::TARGET_BIT];
    assign slot = i_hwdata[exec_unit_pkg::SLOT_MSB:0]; // RULE1
    assign literal = i_hwdata[exec_unit_pkg::LIT_MSB:0];
    assign jump_k = i_hwdata[exec_unit_pkg::JUMP_MSB:0];

    // datapath; 8-bit arithmetic wraps on its own
    assign operand = slot_q[slot];
    assign dec_res = operand - 8'h01; // RULE12
    assign inc_res = operand + 8'h01; // RULE12
    assign or_res = acc_q | literal;

    assign file_op = (op == exec_unit_pkg::OP_DECR)
        || (op == exec_unit_pkg::OP_INCR)
        || (op == exec_unit_pkg::OP_DECR_SKIP)
        || (op == exec_unit_pkg::OP_INCR_SKIP);
    assign skip_op = (op == exec_unit_pkg::OP_DECR_SKIP)
        || (op == exec_unit_pkg::OP_INCR_SKIP);

    always_comb begin
        unique case (op)
            exec_unit_pkg::OP_DECR: file_res = dec_res; // RULE2
            exec_unit_pkg::OP_DECR_SKIP: file_res = dec_res; // RULE4
            exec_unit_pkg::OP_INCR: file_res = inc_res; // RULE11
            exec_unit_pkg::OP_INCR_SKIP: file_res = inc_res; // RULE6
            default: file_res = operand;
        endcase
    end

    // address phase capture; the slave never waits, so hready is high from the first edge after reset
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            dph_valid_q <= 1'b0;
            dph_write_q <= 1'b0;
            dph_addr_q <= 12'h000;
        end else if (i_hready) begin
            dph_valid_q <= addr_phase;
            dph_write_q <= i_hwrite;
            dph_addr_q <= i_haddr[exec_unit_pkg::ADDR_DEC_MSB:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            hreadyout_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
        end
    end

    // last issued word, kept for readback
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            instr_q <= 32'h0000_0000;
        end else if (wr_instr) begin
            instr_q <= i_hwdata;
        end
    end

    // sequencing: jump holds one extra cycle, skip waits for the next word
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_q <= exec_unit_pkg::st_run;
        end else if (exec && op == exec_unit_pkg::OP_JUMP) begin
            state_q <= exec_unit_pkg::st_jump; // RULE9
        end else if (exec && skip_op && file_res == 8'h00) begin
            state_q <= exec_unit_pkg::st_skip; // RULE5 RULE6
        end else if (wr_instr || state_q == exec_unit_pkg::st_jump) begin
            state_q <= exec_unit_pkg::st_run; // RULE13
        end
    end

    // instruction cycles consumed, including the flush and skipped slots
    always_comb begin
        cycles_d = cycles_q;
        if (wr_instr || state_q == exec_unit_pkg::st_jump) begin
            cycles_d = cycles_q + 32'h0000_0001; // RULE9 RULE13
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cycles_q <= exec_unit_pkg::CYCLES_RST;
        end else if (bus_wr && dph_addr_q == exec_unit_pkg::ADDR_CYCLES) begin
            cycles_q <= exec_unit_pkg::CYCLES_RST;
        end else begin
            cycles_q <= cycles_d;
        end
    end

    // accumulator
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            acc_q <= exec_unit_pkg::ACC_RST;
        end else if (exec && file_op && !target) begin
            acc_q <= file_res; // RULE1
        end else if (exec && op == exec_unit_pkg::OP_CLEAR_ACC) begin
            acc_q <= 8'h00; // RULE3
        end else if (exec && op == exec_unit_pkg::OP_OR_LIT) begin
            acc_q <= or_res; // RULE10
        end else if (bus_wr && dph_addr_q == exec_unit_pkg::ADDR_ACC) begin
            acc_q <= i_hwdata[7:0];
        end
    end

    // result null flag; skip variants leave it alone
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            null_q <= 1'b0;
        end else if (exec && file_op && !skip_op) begin
            null_q <= (file_res == 8'h00); // RULE2 RULE11 RULE12
        end else if (exec && op == exec_unit_pkg::OP_CLEAR_ACC) begin
            null_q <= 1'b1; // RULE3
        end else if (exec && op == exec_unit_pkg::OP_OR_LIT) begin
            null_q <= (or_res == 8'h00); // RULE10
        end else if (bus_wr && dph_addr_q == exec_unit_pkg::ADDR_STATUS) begin
            null_q <= i_hwdata[exec_unit_pkg::ST_NULL_BIT];
        end
    end

    // register slots; bus window and execution never hit the same data phase
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int i = 0; i < exec_unit_pkg::SLOTS; i++) begin
                slot_q[i] <= exec_unit_pkg::SLOT_RST;
            end
        end else if (exec && file_op && target) begin
            slot_q[slot] <= file_res; // RULE1
        end else if (wr_file_win) begin
            slot_q[win_slot] <= i_hwdata[7:0];
        end
    end

    // program counter: steps once per issued word, jump reloads it
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pc_q <= exec_unit_pkg::PC_RST;
        end else if (exec && op == exec_unit_pkg::OP_JUMP) begin
            pc_q <= {latch_q[6:3], jump_k}; // RULE7 RULE8
        end else if (wr_instr) begin
            pc_q <= pc_q + 15'h0001;
        end else if (bus_wr && dph_addr_q == exec_unit_pkg::ADDR_PC) begin
            pc_q <= i_hwdata[exec_unit_pkg::PC_W-1:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            latch_q <= exec_unit_pkg::LATCH_RST;
        end else if (bus_wr && dph_addr_q == exec_unit_pkg::ADDR_LATCH) begin
            latch_q <= i_hwdata[exec_unit_pkg::LATCH_W-1:0];
        end
    end

    // read mux, sampled in the address phase; the master never pipelines,
    // so no write is pending behind a read
    assign rd_addr = i_haddr[exec_unit_pkg::ADDR_DEC_MSB:0];
    assign status_word = {29'h0000_0000,
        state_q == exec_unit_pkg::st_jump,
        state_q == exec_unit_pkg::st_skip,
        null_q};

    always_comb begin
        rd_word = 32'h0000_0000;
        if (rd_addr[exec_unit_pkg::FILE_WIN_MSB]) begin
            rd_word = {24'h00_0000, slot_q[rd_addr[8:2]]};
        end else begin
            unique case (rd_addr)
                exec_unit_pkg::ADDR_INSTR: rd_word = instr_q;
                exec_unit_pkg::ADDR_ACC: rd_word = {24'h00_0000, acc_q};
                exec_unit_pkg::ADDR_STATUS: rd_word = status_word;
                exec_unit_pkg::ADDR_PC: rd_word = {17'h0_0000, pc_q};
                exec_unit_pkg::ADDR_LATCH: rd_word = {25'h000_0000, latch_q};
                exec_unit_pkg::ADDR_CYCLES: rd_word = cycles_q;
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_phase && !i_hwrite) begin
            hrdata_q <= rd_word;
        end
    end

    assign o_hrdata = hrdata_q;
    assign o_hreadyout = hreadyout_q;
    assign o_hresp = exec_unit_pkg::HRESP_OKAY;
    assign o_null_flag = null_q;
    assign o_busy = (state_q == exec_unit_pkg::st_jump);
    assign o_program_counter = pc_q;

    AST_TARGET_ACC_KEPT: assert property ( // RULE1
        @(posedge i_clock) disable iff (i_rst)
        exec && file_op && target |=> acc_q == $past(acc_q))
        else $error("slot-target operation changed the accumulator");

    AST_DECR: assert property ( // RULE2
        @(posedge i_clock) disable iff (i_rst)
        exec && op == exec_unit_pkg::OP_DECR && !target
        |=> acc_q == $past(dec_res) && null_q == (acc_q == 8'h00))
        else $error("decrement result or null flag wrong");

    AST_CLEAR_ACC: assert property ( // RULE3
        @(posedge i_clock) disable iff (i_rst)
        exec && op == exec_unit_pkg::OP_CLEAR_ACC
        |=> acc_q == 8'h00 && null_q)
        else $error("clear did not zero accumulator and set null");

    AST_SKIP_NO_STATUS: assert property ( // RULE4
        @(posedge i_clock) disable iff (i_rst)
        exec && skip_op |=> null_q == $past(null_q))
        else $error("skip variant altered the null flag");

    AST_SKIPPED_IS_NOP: assert property ( // RULE5
        @(posedge i_clock) disable iff (i_rst)
        killed |=> acc_q == $past(acc_q) && null_q == $past(null_q)
            && state_q == exec_unit_pkg::st_run)
        else $error("skipped word was not a no-operation");

    AST_INCR_SKIP: assert property ( // RULE6
        @(posedge i_clock) disable iff (i_rst)
        exec && op == exec_unit_pkg::OP_INCR_SKIP && inc_res == 8'h00
        |=> state_q == exec_unit_pkg::st_skip)
        else $error("zero increment did not arm the skip");

    AST_JUMP_LOW: assert property ( // RULE7
        @(posedge i_clock) disable iff (i_rst)
        exec && op == exec_unit_pkg::OP_JUMP
        |=> pc_q[10:0] == $past(jump_k))
        else $error("jump target not in counter low bits");

    AST_JUMP_HIGH: assert property ( // RULE8
        @(posedge i_clock) disable iff (i_rst)
        exec && op == exec_unit_pkg::OP_JUMP
        |=> pc_q[14:11] == $past(latch_q[6:3]))
        else $error("counter high bits not from latch");

    AST_JUMP_TWO_CYCLES: assert property ( // RULE9
        @(posedge i_clock) disable iff (i_rst)
        exec && op == exec_unit_pkg::OP_JUMP
        |=> state_q == exec_unit_pkg::st_jump
        ##1 state_q == exec_unit_pkg::st_run
            && cycles_q == $past(cycles_q, 2) + 32'h0000_0002)
        else $error("jump did not take two cycles");

    AST_OR_LIT: assert property ( // RULE10
        @(posedge i_clock) disable iff (i_rst)
        exec && op == exec_unit_pkg::OP_OR_LIT
        |=> acc_q == $past(or_res) && null_q == (acc_q == 8'h00))
        else $error("literal OR result or null flag wrong");

    AST_INCR: assert property ( // RULE11
        @(posedge i_clock) disable iff (i_rst)
        exec && op == exec_unit_pkg::OP_INCR && target
        |=> slot_q[$past(slot)] == $past(inc_res)
            && null_q == ($past(inc_res) == 8'h00))
        else $error("increment result or null flag wrong");

    AST_DECR_WRAP: assert property ( // RULE12
        @(posedge i_clock) disable iff (i_rst)
        exec && op == exec_unit_pkg::OP_DECR && !target && operand == 8'h00
        |=> acc_q == 8'hff && !null_q)
        else $error("decrement of zero did not wrap");

    AST_SINGLE_CYCLE: assert property ( // RULE13
        @(posedge i_clock) disable iff (i_rst)
        exec && op != exec_unit_pkg::OP_JUMP && !(skip_op && file_res == 8'h00)
        |=> state_q == exec_unit_pkg::st_run
            && cycles_q == $past(cycles_q) + 32'h0000_0001)
        else $error("plain instruction took more than one cycle");

endmodule : exec_unit

//--- dv/exec_unit_bench.sv
// self-checking bench for exec_unit over the register bus
module exec_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_hsel = 1'b0;
    logic [31:0] i_haddr = 32'h0000_0000;
    logic [1:0] i_htrans = 2'h0;
    logic i_hwrite = 1'b0;
    logic [2:0] i_hsize = 3'h2;
    logic [31:0] i_hwdata = 32'h0000_0000;
    logic i_hready;
    logic [31:0] o_hrdata;
    logic o_hreadyout;
    logic o_hresp;
    logic o_null_flag;
    logic o_busy;
    logic [14:0] o_program_counter;

    int n_fail = 0;
    int samples_checked = 0;
    logic rd_dp = 1'b0;
    logic [31:0] expq[$];
    logic [31:0] rs = 32'd96015;
    // bench model of the architectural state
    logic [7:0] acc = 8'h00;
    logic nul = 1'b0;
    logic skp = 1'b0;
    logic [14:0] pc = 15'h0000;
    logic [6:0] lat = 7'h00;
    logic [31:0] cyc = 32'h0000_0000;
    logic [7:0] slot[128];

    assign i_hready = o_hreadyout;
    always #20 i_clock = ~i_clock;

    exec_unit u_exec_unit (
        .i_clock(i_clock), .i_rst(i_rst), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
        .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .o_null_flag(o_null_flag), .o_busy(o_busy),
        .o_program_counter(o_program_counter)
    );

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd

    task automatic results();
        $display("checked %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // bounded wait for the edge at which hready is sampled high
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (o_hreadyout !== 1'b1 && k < 40);
        if (o_hreadyout !== 1'b1) begin
            n_fail++;
            results();
        end
    endtask : wait_rdy

    // upper address bits are random: the slave decodes only the low twelve
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d);
        logic [31:0] r;
        r = rnd();
        @(posedge i_clock);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_hwrite <= w;
        i_haddr <= {r[19:0], a};
        wait_rdy();
        i_htrans <= 2'h0;
        i_hwdata <= w ? d : r;
        rd_dp <= ~w;
        wait_rdy();
        rd_dp <= 1'b0;
        i_hsel <= 1'b0;
    endtask : xfer

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        xfer(a, 1'b0, 32'h0000_0000);
    endtask : rd

    function automatic logic [11:0] slot_addr(input logic [6:0] n);
        return exec_unit_pkg::ADDR_FILE_BASE + {3'h0, n, 2'h0};
    endfunction : slot_addr

    task automatic issue(input logic [15:0] w);
        logic [3:0] op;
        logic [7:0] r;
        logic jmp;
        op = w[15:12];
        jmp = 1'b0;
        xfer(exec_unit_pkg::ADDR_INSTR, 1'b1, {16'h0000, w});
        pc = pc + 15'h0001;
        cyc = cyc + 32'h1;
        if (skp) begin
            skp = 1'b0;
        end else begin
            case (op)
                exec_unit_pkg::OP_DECR, exec_unit_pkg::OP_INCR,
                exec_unit_pkg::OP_DECR_SKIP, exec_unit_pkg::OP_INCR_SKIP: begin
                    if (op == exec_unit_pkg::OP_DECR
                        || op == exec_unit_pkg::OP_DECR_SKIP) begin
                        r = slot[w[6:0]] - 8'h01;
                    end else begin
                        r = slot[w[6:0]] + 8'h01;
                    end
                    if (w[7]) slot[w[6:0]] = r;
                    else acc = r;
                    if (op == exec_unit_pkg::OP_DECR
                        || op == exec_unit_pkg::OP_INCR) nul = (r == 8'h00);
                    else skp = (r == 8'h00);
                end
                exec_unit_pkg::OP_CLEAR_ACC: begin
                    acc = 8'h00;
                    nul = 1'b1;
                end
                exec_unit_pkg::OP_OR_LIT: begin
                    acc = acc | w[7:0];
                    nul = (acc == 8'h00);
                end
                exec_unit_pkg::OP_JUMP: begin
                    pc = {lat[6:3], w[10:0]};
                    cyc = cyc + 32'h1;
                    jmp = 1'b1;
                end
                default: ;
            endcase
        end
        #1;
        check({17'h0, o_program_counter}, {17'h0, pc});
        check({31'h0, o_null_flag}, {31'h0, nul});
        check({31'h0, o_busy}, {31'h0, jmp});
        if (jmp) begin
            @(posedge i_clock);
            #1;
            check({31'h0, o_busy}, 32'h0);
        end
    endtask : issue

    // read answers are compared in order against the noted expectations
    always @(posedge i_clock) begin
        if (rd_dp && o_hreadyout) begin
            if (expq.size() == 0) begin
                n_fail++;
            end else begin
                check(o_hrdata, expq.pop_front());
                check({31'h0, o_hresp}, 32'h0);
            end
        end
    end

    initial begin
        logic [7:0] vals[5];
        logic [31:0] r;
        logic [6:0] n;
        logic [3:0] op;
        logic [15:0] w;
        vals = '{8'h00, 8'h01, 8'hff, 8'h80, 8'h5a};
        foreach (slot[i]) slot[i] = 8'h00;
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        rd(exec_unit_pkg::ADDR_ACC, 32'h0);
        rd(exec_unit_pkg::ADDR_STATUS, 32'h0);
        rd(exec_unit_pkg::ADDR_CYCLES, 32'h0);
        rd(slot_addr(7'h7f), 32'h0);
        rd(12'h020, 32'h0);
        for (int t = 0; t < 35; t++) begin
            r = rnd();
            n = (t < 2) ? 7'(t * 127) : r[6:0];
            op = 4'(t % 7 + 1);
            slot[n] = (t % 5 == 4) ? r[15:8] : vals[t % 5];
            acc = (t % 3 == 0) ? 8'h00 : r[23:16];
            lat = r[30:24];
            xfer(slot_addr(n), 1'b1, {24'h0, slot[n]});
            xfer(exec_unit_pkg::ADDR_ACC, 1'b1, {24'h0, acc});
            xfer(exec_unit_pkg::ADDR_LATCH, 1'b1, {25'h0, lat});
            w = {op, r[11:0]};
            w[6:0] = n;
            w[7] = r[31];
            if (op == exec_unit_pkg::OP_OR_LIT && t % 2 == 1) w[7:0] = 8'h00;
            issue(w);
            rd(exec_unit_pkg::ADDR_ACC, {24'h0, acc});
            rd(slot_addr(n), {24'h0, slot[n]});
            rd(exec_unit_pkg::ADDR_STATUS, {30'h0, skp, nul});
            rd(exec_unit_pkg::ADDR_PC, {17'h0, pc});
            rd(exec_unit_pkg::ADDR_CYCLES, cyc);
        end
        // bus writes of counter, cycle count and status, then plain no-ops
        r = rnd();
        xfer(exec_unit_pkg::ADDR_PC, 1'b1, {17'h0, r[14:0]});
        pc = r[14:0];
        xfer(exec_unit_pkg::ADDR_CYCLES, 1'b1, r);
        cyc = 32'h0;
        xfer(exec_unit_pkg::ADDR_STATUS, 1'b1, 32'h1);
        nul = 1'b1;
        issue(16'h0000);
        issue(16'h8000);
        rd(exec_unit_pkg::ADDR_STATUS, {30'h0, skp, nul});
        rd(exec_unit_pkg::ADDR_CYCLES, cyc);
        repeat (2) @(posedge i_clock);
        check(32'(expq.size()), 32'h0);
        results();
    end
endmodule : exec_unit_bench
